// ===== design/scf_exec.sv
// Purpose: Signed compares and int-to-float round-to-zero flag op
// Assumes: One issue per cycle from the core, Wishbone for registers
// Notes:   Separate writeback ports so both latencies never collide
//
// How it works
// RL1: Flag op writes exceptions of signed int to single float conversion.
// RL2: Flag vector uses status-word exception layout; inexact is 0x02.
// RL3: Flag op never changes the exception flags of the status word.
// RL4: Flag op always rounds toward zero, ignoring status-word rounding mode.
// RL5: Guard LSB one writes destination; zero leaves it unchanged.
// RL6: Signed register compare writes 1 when first >= second, else 0.
// RL7: Signed immediate compare writes 1 when first >= 7-bit modifier.
// RL8: Signed register compare writes 1 only when first > second.
// RL9: Signed immediate compare writes 1 only when first > 7-bit modifier.
// RL10: Compares take one cycle any slot; flag op three cycles, slots 1,4.
// RL11: Compare result fills 32 bits, value 1 or 0, upper bits clear.
module scf_exec
  import scf_pkg::*;
#(
  parameter int DEST_W = 7
) (
  input  wire logic              sys_clk,      // Core clock, 20 MHz
  input  wire logic              reset,        // Sync reset, high
  input  wire logic              wb_cyc_i,     // Wishbone cycle
  input  wire logic              wb_stb_i,     // Wishbone strobe
  input  wire logic              wb_we_i,      // Wishbone write
  input  wire logic [7:0]        wb_adr_i,     // Byte address
  input  wire logic [3:0]        wb_sel_i,     // Byte enables
  input  wire logic [31:0]       wb_dat_i,     // Write data
  output logic [31:0]            wb_dat_o,     // Read data
  output logic                   wb_ack_o,     // Acknowledge
  input  wire logic              iss_valid,    // Operation issued
  input  wire logic [7:0]        iss_op,       // Operation code
  input  wire logic [2:0]        iss_slot,     // Issue slot 1..5
  input  wire logic [31:0]       iss_src1,     // First source
  input  wire logic [31:0]       iss_src2,     // Second source
  input  wire logic [IMM_W-1:0]  iss_imm,      // Signed modifier
  input  wire logic              iss_guard_en, // Guard present
  input  wire logic [31:0]       iss_guard,    // Guard register
  input  wire logic [DEST_W-1:0] iss_dest,     // Destination index
  output logic                   iss_refused,  // Issue not taken
  output logic                   int_wb_valid, // Compare retires
  output logic                   int_wb_we,    // Compare writes dest
  output logic [DEST_W-1:0]      int_wb_dest,  // Compare dest index
  output logic [31:0]            int_wb_data,  // Compare result
  output logic                   flt_wb_valid, // Flag op retires
  output logic                   flt_wb_we,    // Flag op writes dest
  output logic [DEST_W-1:0]      flt_wb_dest,  // Flag op dest index
  output logic [31:0]            flt_wb_data,  // Flag vector
  output logic [31:0]            program_control_status_word_o        // Status word
);

  localparam int PIPE_W = 1 + DEST_W + DATA_W;

  logic              ack_q, ack_d;
  logic [31:0]       rdat_q, rdat_d;
  logic [31:0]       ctrl_q, ctrl_d;
  logic [31:0]       program_control_status_word_q, program_control_status_word_d;
  logic [15:0]       refused_cnt_q, refused_cnt_d;
  logic [31:0]       last_q, last_d;
  logic              iv_q, iv_d;
  logic              iwe_q, iwe_d;
  logic [DEST_W-1:0] idst_q, idst_d;
  logic [31:0]       idat_q, idat_d;

  logic              bus_req;
  logic              bus_wr;
  logic              is_int;
  logic              is_flt;
  logic              slot_ok;
  logic              take_int;
  logic              take_flt;
  logic              wr_en;
  logic signed [31:0] s1;
  logic signed [31:0] s2;
  logic signed [31:0] simm;
  logic [31:0]       flags_vec;
  logic [PIPE_W-1:0] pipe_out;
  logic              pipe_vld;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // Inexact when set bits span more than the significand holds
  function automatic logic rz_inexact(input logic [31:0] v);
    logic [32:0] mag;
    int          hi;
    int          lo;
    mag = v[31] ? (33'h0_0000_0000 - {1'b1, v}) : {1'b0, v};
    hi  = 0;
    lo  = 32;
    for (int i = 0; i < 33; i++) begin
      if (mag[i]) begin
        hi = i;
      end
    end
    for (int i = 32; i >= 0; i--) begin
      if (mag[i]) begin
        lo = i;
      end
    end
    return (lo <= hi) && ((hi - lo) >= SIG_BITS);
  endfunction : rz_inexact

  // Register bus
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr  = bus_req && wb_we_i;

  always_comb begin
    ack_d  = bus_req;
    rdat_d = rdat_q;
    ctrl_d = ctrl_q;
    program_control_status_word_d = program_control_status_word_q;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        REG_CTRL: rdat_d = ctrl_q;
        REG_PROGRAM_CONTROL_STATUS_WORD: rdat_d = program_control_status_word_q;
        REG_STAT: rdat_d = {16'h0000, refused_cnt_q};
        REG_LAST: rdat_d = last_q;
        default:  rdat_d = 32'h0000_0000;
      endcase
    end
    if (bus_wr && wb_adr_i == REG_CTRL) begin
      ctrl_d = merge_bytes(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0001;
    end
    // Only software writes reach the status word
    if (bus_wr && wb_adr_i == REG_PROGRAM_CONTROL_STATUS_WORD) begin // RL3
      program_control_status_word_d = merge_bytes(program_control_status_word_q, wb_dat_i, wb_sel_i) & PROGRAM_CONTROL_STATUS_WORD_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
      ctrl_q <= CTRL_RST;
      program_control_status_word_q <= PROGRAM_CONTROL_STATUS_WORD_RST;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
      program_control_status_word_q <= program_control_status_word_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign program_control_status_word_o   = program_control_status_word_q;

  // Issue decode
  assign is_int = (iss_op == SCF_OP_GE) || (iss_op == SCF_OP_GT) ||
                  (iss_op == SCF_OP_GEI) || (iss_op == SCF_OP_GTI);
  assign is_flt = (iss_op == SCF_OP_FLAGS);
  assign slot_ok = is_int ? (iss_slot >= 3'h1 && iss_slot <= 3'(NUM_SLOT))
                          : (iss_slot == FLT_SLOT_A ||
                             iss_slot == FLT_SLOT_B); // RL10
  assign take_int = iss_valid && ctrl_q[0] && is_int && slot_ok;
  assign take_flt = iss_valid && ctrl_q[0] && is_flt && slot_ok;
  assign iss_refused = iss_valid && !(take_int || take_flt);
  assign wr_en = !iss_guard_en || iss_guard[0]; // RL5

  assign s1   = $signed(iss_src1);
  assign s2   = $signed(iss_src2);
  assign simm = 32'($signed(iss_imm));

  always_comb begin
    iv_d   = take_int; // RL10
    iwe_d  = take_int && wr_en; // RL5
    idst_d = iss_dest;
    idat_d = RESULT_ZERO; // RL11
    if (take_int) begin
      unique case (iss_op)
        SCF_OP_GE:  idat_d = (s1 >= s2)   ? RESULT_ONE : RESULT_ZERO; // RL6
        SCF_OP_GT:  idat_d = (s1 > s2)    ? RESULT_ONE : RESULT_ZERO; // RL8
        SCF_OP_GEI: idat_d = (s1 >= simm) ? RESULT_ONE : RESULT_ZERO; // RL7
        SCF_OP_GTI: idat_d = (s1 > simm)  ? RESULT_ONE : RESULT_ZERO; // RL9
        default:    idat_d = RESULT_ZERO;
      endcase
    end
    refused_cnt_d = refused_cnt_q + 16'(iss_refused);
    last_d = (pipe_vld && pipe_out[PIPE_W-1]) ? pipe_out[DATA_W-1:0]
                                              : last_q;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      iv_q          <= 1'b0;
      iwe_q         <= 1'b0;
      idst_q        <= '0;
      idat_q        <= 32'h0000_0000;
      refused_cnt_q <= 16'h0000;
      last_q        <= 32'h0000_0000;
    end else begin
      iv_q          <= iv_d;
      iwe_q         <= iwe_d;
      idst_q        <= idst_d;
      idat_q        <= idat_d;
      refused_cnt_q <= refused_cnt_d;
      last_q        <= last_d;
    end
  end

  assign int_wb_valid = iv_q;
  assign int_wb_we    = iwe_q;
  assign int_wb_dest  = idst_q;
  assign int_wb_data  = idat_q;

  // Conversion to single cannot overflow, so only inexact can arise.
  // Rounding mode bits are never read: truncation is fixed.
  always_comb begin
    flags_vec = 32'h0000_0000;
    flags_vec[FLAG_INX_BIT] = rz_inexact(iss_src1); // RL1 RL2 RL4
  end

  scf_delay #(
    .W     (PIPE_W),
    .DEPTH (FLT_LAT)
  ) u_flt_pipe (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .in_vld   (take_flt), // RL10
    .in_data  ({wr_en, iss_dest, flags_vec}), // RL5
    .out_vld  (pipe_vld),
    .out_data (pipe_out)
  );

  assign flt_wb_valid = pipe_vld;
  assign flt_wb_we    = pipe_vld && pipe_out[PIPE_W-1];
  assign flt_wb_dest  = pipe_out[DATA_W +: DEST_W];
  assign flt_wb_data  = pipe_out[DATA_W-1:0];

  chk_int_latency: assert property (@(posedge sys_clk) disable iff (reset)
    take_int |=> int_wb_valid) // RL10
    else $error("compare result missing after one cycle");
  chk_flt_latency: assert property (@(posedge sys_clk) disable iff (reset)
    take_flt |-> ##3 flt_wb_valid) // RL10
    else $error("flag result not at third cycle");
  chk_flt_origin: assert property (@(posedge sys_clk) disable iff (reset)
    flt_wb_valid |-> $past(take_flt, 3)) // RL10
    else $error("flag result without matching issue");
  chk_flt_slot: assert property (@(posedge sys_clk) disable iff (reset)
    iss_valid && is_flt && iss_slot != FLT_SLOT_A && iss_slot != FLT_SLOT_B
    |-> iss_refused) // RL10
    else $error("flag op taken from wrong slot");
  chk_ge_value: assert property (@(posedge sys_clk) disable iff (reset)
    take_int && iss_op == SCF_OP_GE |=> int_wb_data ==
    (($signed($past(iss_src1)) >= $signed($past(iss_src2))) ? 1 : 0)) // RL6
    else $error("ge compare wrong");
  chk_gt_value: assert property (@(posedge sys_clk) disable iff (reset)
    take_int && iss_op == SCF_OP_GT && iss_src1 == iss_src2
    |=> int_wb_data == RESULT_ZERO) // RL8
    else $error("gt compare true on equal");
  chk_gei_value: assert property (@(posedge sys_clk) disable iff (reset)
    take_int && iss_op == SCF_OP_GEI && s1 == simm
    |=> int_wb_data == RESULT_ONE) // RL7
    else $error("ge immediate false on equal");
  chk_gti_value: assert property (@(posedge sys_clk) disable iff (reset)
    take_int && iss_op == SCF_OP_GTI && s1 == simm + 1
    |=> int_wb_data == RESULT_ONE) // RL9
    else $error("gt immediate wrong");
  chk_upper_clear: assert property (@(posedge sys_clk) disable iff (reset)
    int_wb_valid |-> int_wb_data[31:1] == 31'h0000_0000) // RL11
    else $error("compare upper bits set");
  chk_guard_hold: assert property (@(posedge sys_clk) disable iff (reset)
    (take_int || take_flt) && iss_guard_en && !iss_guard[0]
    |=> !int_wb_we ##2 !flt_wb_we) // RL5
    else $error("false guard wrote destination");
  chk_program_control_status_word_hold: assert property (@(posedge sys_clk) disable iff (reset)
    !(bus_wr && wb_adr_i == REG_PROGRAM_CONTROL_STATUS_WORD) |=> $stable(program_control_status_word_q)) // RL3
    else $error("status word changed without write");
  chk_inx_value: assert property (@(posedge sys_clk) disable iff (reset)
    take_flt && iss_src1 == 32'h7fff_ffff
    |-> ##3 flt_wb_data == 32'h0000_0002) // RL1 RL2 RL4
    else $error("inexact flag not reported");
  chk_exact_value: assert property (@(posedge sys_clk) disable iff (reset)
    take_flt && iss_src1 == 32'h8000_0000
    |-> ##3 flt_wb_data == 32'h0000_0000) // RL1
    else $error("spurious flag on exact value");

  cov_int_write: cover property (@(posedge sys_clk) int_wb_we);
  cov_flt_inx: cover property (@(posedge sys_clk)
    flt_wb_we && flt_wb_data[FLAG_INX_BIT]);
  cov_guard_false: cover property (@(posedge sys_clk)
    take_int && iss_guard_en && !iss_guard[0]);
  cov_refused: cover property (@(posedge sys_clk) iss_refused);

endmodule : scf_exec

// ===== design/scf_pkg.sv
// Purpose: Shared constants for the signed compare and float flag unit
// Assumes: 32-bit data, classic Wishbone register access
// Notes:   Operation codes match the issue encoding of the core
package scf_pkg;

  localparam int DATA_W   = 32;
  localparam int INT_LAT  = 1;
  localparam int FLT_LAT  = 3;
  localparam int IMM_W    = 7;
  localparam int NUM_SLOT = 5;

  typedef enum logic [7:0] {
    SCF_OP_GTI   = 8'h00,
    SCF_OP_GEI   = 8'h01,
    SCF_OP_GE    = 8'h0e,
    SCF_OP_GT    = 8'h0f,
    SCF_OP_FLAGS = 8'h76
  } scf_op_e;

  // Slots allowed for the float flag operation
  localparam logic [2:0] FLT_SLOT_A = 3'h1;
  localparam logic [2:0] FLT_SLOT_B = 3'h4;

  // Exception flag layout, shared with the status word
  localparam int FLAG_W       = 5;
  localparam int FLAG_INX_BIT = 1;
  localparam int RM_LSB       = 8;
  localparam int RM_W         = 2;
  localparam int SIG_BITS     = 24;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PROGRAM_CONTROL_STATUS_WORD = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_LAST = 8'h0c;

  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] PROGRAM_CONTROL_STATUS_WORD_RST = 32'h0000_0000;
  localparam logic [31:0] PROGRAM_CONTROL_STATUS_WORD_MASK = 32'h0000_031f;
  localparam logic [31:0] RESULT_ONE  = 32'h0000_0001;
  localparam logic [31:0] RESULT_ZERO = 32'h0000_0000;

endpackage : scf_pkg

// ===== design/scf_delay.sv
// Purpose: Fixed-depth valid/data delay line for the float pipe
// Assumes: DEPTH of at least two
// Notes:   No stall; every stage advances each cycle
module scf_delay
  import scf_pkg::*;
#(
  parameter int W     = 40,
  parameter int DEPTH = 3
) (
  input  wire logic         sys_clk,  // Core clock
  input  wire logic         reset,    // Sync reset, high
  input  wire logic         in_vld,   // Stage 0 valid
  input  wire logic [W-1:0] in_data,  // Stage 0 data
  output logic              out_vld,  // Last stage valid
  output logic [W-1:0]      out_data  // Last stage data
);

  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] vld_d;
  logic [W-1:0]     dat_q [DEPTH];
  logic [W-1:0]     dat_d [DEPTH];

  always_comb begin
    vld_d    = {vld_q[DEPTH-2:0], in_vld};
    dat_d[0] = in_data;
    for (int i = 1; i < DEPTH; i++) begin
      dat_d[i] = dat_q[i-1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      vld_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        dat_q[i] <= '0;
      end
    end else begin
      vld_q <= vld_d;
      for (int i = 0; i < DEPTH; i++) begin
        dat_q[i] <= dat_d[i];
      end
    end
  end

  assign out_vld  = vld_q[DEPTH-1];
  assign out_data = dat_q[DEPTH-1];

endmodule : scf_delay

// ===== verif/scf_rf_model.sv
// Purpose: Core register file that takes the unit's writebacks
// Assumes: Writebacks come as one-cycle pulses on two ports
// Notes:   Keeping entries on guard-false retirements is the point
module scf_rf_model
  import scf_pkg::*;
(
  input  wire logic        sys_clk,   // Core clock
  input  wire logic        int_valid, // Compare retires
  input  wire logic        int_we,    // Compare writes
  input  wire logic [6:0]  int_dest,  // Compare index
  input  wire logic [31:0] int_data,  // Compare value
  input  wire logic        flt_valid, // Flag op retires
  input  wire logic        flt_we,    // Flag op writes
  input  wire logic [6:0]  flt_dest,  // Flag op index
  input  wire logic [31:0] flt_data,  // Flag op value
  input  wire logic [6:0]  rd_idx,    // Read index
  output logic      [31:0] rd_data    // Read value
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] regs_q [128];
  always_ff @(posedge sys_clk) begin
    if (int_valid && int_we) regs_q[int_dest] <= int_data;
    if (flt_valid && flt_we) regs_q[flt_dest] <= flt_data;
  end
  assign rd_data = regs_q[rd_idx];
endmodule : scf_rf_model

// ===== verif/scf_exec_tb.sv
// Purpose: Self-checking bench for the compare and flag unit
// Assumes: Latencies and register map as the design states them
// Notes:   Each scenario is its own task and judges its own results
module scf_exec_tb;
  import scf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, iss_op;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, iss_src1, iss_src2, iss_guard, program_control_status_word_o;
  logic        iss_valid, iss_guard_en, iss_refused, ref_q;
  logic [2:0]  iss_slot;
  logic [6:0]  iss_imm, iss_dest, int_wb_dest, flt_wb_dest, rd_idx;
  logic        int_wb_valid, int_wb_we, flt_wb_valid, flt_wb_we;
  logic [31:0] int_wb_data, flt_wb_data, rd_data, rdat;
  int          err_count, cmp_count;

  scf_exec #(.DEST_W(7)) dut (
    .sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .iss_valid, .iss_op,
    .iss_slot, .iss_src1, .iss_src2, .iss_imm, .iss_guard_en,
    .iss_guard, .iss_dest, .iss_refused, .int_wb_valid, .int_wb_we,
    .int_wb_dest, .int_wb_data, .flt_wb_valid, .flt_wb_we,
    .flt_wb_dest, .flt_wb_data, .program_control_status_word_o
  );
  scf_rf_model rf (
    .sys_clk, .int_valid(int_wb_valid), .int_we(int_wb_we),
    .int_dest(int_wb_dest), .int_data(int_wb_data),
    .flt_valid(flt_wb_valid), .flt_we(flt_wb_we),
    .flt_dest(flt_wb_dest), .flt_data(flt_wb_data),
    .rd_idx, .rd_data
  );

  always #25 sys_clk = ~sys_clk;

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  // Classic cycle; waits up to 20 cycles for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    chk("wb_ack_o", 32'h0000_0001, {31'h0, wb_ack_o});
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  // One-cycle issue; returns just after the edge that takes it
  task automatic iss(input logic [7:0] op, input logic [2:0] sl,
                     input logic [31:0] s1, s2, input logic [6:0] im,
                     input logic ge, input logic [31:0] g,
                     input logic [6:0] d);
    @(posedge sys_clk);
    iss_valid    <= 1'b1;
    iss_op       <= op;
    iss_slot     <= sl;
    iss_src1     <= s1;
    iss_src2     <= s2;
    iss_imm      <= im;
    iss_guard_en <= ge;
    iss_guard    <= g;
    iss_dest     <= d;
    #1 ref_q = iss_refused;
    @(posedge sys_clk);
    iss_valid <= 1'b0;
    #1;
  endtask : iss

  function automatic logic [31:0] inexact_flag(input logic [31:0] v);
    logic [31:0] m;
    int p;
    m = v[31] ? -v : v;
    p = 0;
    for (int j = 0; j < 32; j++) if (m[j]) p = j;
    if (p >= 24 && (m & ((32'h0000_0001 << (p - 23)) - 1)) != 0)
      return 32'h0000_0002;
    return 32'h0000_0000;
  endfunction : inexact_flag

  task automatic t_regs;
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", CTRL_RST, rdat);
    wb(1'b0, REG_PROGRAM_CONTROL_STATUS_WORD, 32'h0);
    chk("program_control_status_word", PROGRAM_CONTROL_STATUS_WORD_RST, rdat);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0000_0000, rdat);
    // Only lane one enabled: rounding bits land, flag bits stay clear
    wb_sel_i <= 4'h2;
    wb(1'b1, REG_PROGRAM_CONTROL_STATUS_WORD, 32'hffff_ffff);
    wb_sel_i <= 4'hf;
    wb(1'b0, REG_PROGRAM_CONTROL_STATUS_WORD, 32'h0);
    chk("program_control_status_word lane", PROGRAM_CONTROL_STATUS_WORD_MASK & 32'h0000_ff00, rdat);
  endtask : t_regs

  task automatic t_compares;
    logic [31:0] a [8] = '{32'h3, 32'h3, 32'h3, 32'h8000_0000, 32'h100,
                           32'hffff_ffc0, 32'hffff_ffbf, 32'h7fff_ffff};
    logic [31:0] b [8] = '{32'h2, 32'h3, 32'h4, 32'hffff_ffc0, 32'h3f,
                           32'hffff_ffc0, 32'hffff_ffc0, 32'h1000};
    logic [7:0]  ops [4] = '{SCF_OP_GE, SCF_OP_GEI, SCF_OP_GT, SCF_OP_GTI};
    logic [31:0] r;
    logic [31:0] e;
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 4; k++) begin
        r = k[0] ? {{25{b[i][6]}}, b[i][6:0]} : b[i];
        e = (k < 2) ? {31'h0, $signed(a[i]) >= $signed(r)}
                    : {31'h0, $signed(a[i]) > $signed(r)};
        iss(ops[k], 3'(1 + (i + k) % 5), a[i], b[i], b[i][6:0], 1'b0,
            32'h0, 7'(i));
        chk("int_wb_valid", 32'h1, {31'h0, int_wb_valid});
        chk("int_wb_data", e, int_wb_data);
        chk("int_wb_dest", 32'(i), {25'h0, int_wb_dest});
      end
    end
  endtask : t_compares

  task automatic t_guard;
    iss(SCF_OP_GE, 3'h2, 32'h3, 32'h2, 7'h0, 1'b1, 32'h1, 7'h05);
    chk("int_wb_we", 32'h1, {31'h0, int_wb_we});
    iss(SCF_OP_GT, 3'h3, 32'h3, 32'h4, 7'h0, 1'b1, 32'hffff_fffe, 7'h05);
    chk("int_wb_we", 32'h0, {31'h0, int_wb_we});
    rd_idx = 7'h05;
    @(posedge sys_clk);
    #1 chk("dest kept", 32'h1, rd_data);
  endtask : t_guard

  task automatic t_flags;
    logic [31:0] v [8] = '{32'h3, 32'hffff_ffff, 32'h7fff_ffff,
                           32'h8000_0000, 32'h7fff_fff1, 32'h0100_0001,
                           32'h00ff_ffff, 32'hfeff_ffff};
    // Sticky flags plus a non-zero rounding mode
    wb(1'b1, REG_PROGRAM_CONTROL_STATUS_WORD, 32'h0000_0215);
    foreach (v[i]) begin
      iss(SCF_OP_FLAGS, i[0] ? FLT_SLOT_B : FLT_SLOT_A, v[i], 32'h0,
          7'h0, 1'b1, 32'h1, 7'(20 + i));
      repeat (2) @(posedge sys_clk);
      #1 chk("flt_wb_valid", 32'h1, {31'h0, flt_wb_valid});
      chk("flt_wb_data", inexact_flag(v[i]), flt_wb_data);
    end
    rd_idx = 7'd22;
    #1 chk("flag dest", inexact_flag(v[2]), rd_data);
    // Exact source: a wrong write would clear the last vector
    iss(SCF_OP_FLAGS, FLT_SLOT_A, 32'h0000_0003, 32'h0, 7'h0, 1'b1,
        32'h0, 7'd30);
    repeat (2) @(posedge sys_clk);
    #1 chk("flt_wb_valid", 32'h1, {31'h0, flt_wb_valid});
    chk("flt_wb_we", 32'h0, {31'h0, flt_wb_we});
    wb(1'b0, REG_LAST, 32'h0);
    chk("last", inexact_flag(v[7]), rdat);
    wb(1'b0, REG_PROGRAM_CONTROL_STATUS_WORD, 32'h0);
    chk("program_control_status_word", 32'h0000_0215, rdat);
    chk("program_control_status_word_o", 32'h0000_0215, program_control_status_word_o);
  endtask : t_flags

  task automatic t_refuse;
    iss(SCF_OP_FLAGS, 3'h2, 32'h7fff_ffff, 32'h0, 7'h0, 1'b0, 32'h0, 7'h0);
    chk("iss_refused", 32'h1, {31'h0, ref_q});
    repeat (2) @(posedge sys_clk);
    #1 chk("flt_wb_valid", 32'h0, {31'h0, flt_wb_valid});
    iss(SCF_OP_GE, 3'h0, 32'h3, 32'h2, 7'h0, 1'b0, 32'h0, 7'h0);
    chk("iss_refused", 32'h1, {31'h0, ref_q});
    chk("int_wb_valid", 32'h0, {31'h0, int_wb_valid});
    wb(1'b1, REG_CTRL, 32'h0);
    iss(SCF_OP_GT, 3'h1, 32'h3, 32'h2, 7'h0, 1'b0, 32'h0, 7'h0);
    chk("iss_refused", 32'h1, {31'h0, ref_q});
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b0, REG_STAT, 32'h0);
    chk("stat", 32'h0000_0003, rdat);
  endtask : t_refuse

  task automatic conclude;
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  initial begin
    {sys_clk, wb_cyc_i, wb_stb_i, wb_we_i, iss_valid, iss_guard_en} = '0;
    {wb_adr_i, iss_op, iss_slot, iss_imm, iss_dest, rd_idx} = '0;
    {wb_dat_i, iss_src1, iss_src2, iss_guard} = '0;
    wb_sel_i = 4'hf;
    reset = 1'b1;
    err_count = 0;
    cmp_count = 0;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_compares();
    t_guard();
    t_flags();
    t_refuse();
    conclude();
  end

  // Run needs well under a thousand cycles
  initial begin
    #(50 * 3000);
    err_count++;
    conclude();
  end
endmodule : scf_exec_tb
